// *** rtl/via_pkg.sv ***
/*
 * Constants shared by the interrupt acknowledge block: register offsets,
 * status word layout, reset values, vectors, latency figures and entry states.
 * Assumes a single 200 MHz CPU clock and a 32-bit AHB-Lite register bus.
 */
package via_pkg;

    // Register byte offsets on the AHB-Lite bus
    localparam logic [7:0] VIA_OFS_REQUEST = 8'h00;
    localparam logic [7:0] VIA_OFS_MASK    = 8'h04;
    localparam logic [7:0] VIA_OFS_LEVEL   = 8'h08;
    localparam logic [7:0] VIA_OFS_PSW     = 8'h0c;
    localparam logic [7:0] VIA_OFS_STATUS  = 8'h10;

    // Program status word layout and reset value
    localparam int         VIA_PSW_ACCEPT_BIT = 7;
    localparam int         VIA_PSW_LEVEL_BIT  = 1;
    localparam logic [7:0] VIA_PSW_RESET      = 8'h02;

    // Status register field positions
    localparam int VIA_ST_BUSY_BIT  = 0;
    localparam int VIA_ST_TRAP_BIT  = 1;
    localparam int VIA_ST_HOLD_BIT  = 2;
    localparam int VIA_ST_SRC_LSB   = 8;

    // Vectors: maskable table base, two bytes per entry; trap entry fixed
    localparam logic [15:0] VIA_VEC_BASE = 16'h0004;
    localparam logic [15:0] VIA_VEC_TRAP = 16'h003e;

    // Least and worst request-to-entry times in CPU clocks, per level
    localparam int VIA_LAT_HI_CLK = 7;
    localparam int VIA_LAT_LO_CLK = 8;
    localparam int VIA_LAT_HI_MAX_CLK = 32;
    localparam int VIA_LAT_LO_MAX_CLK = 33;
    // Clocks of the request-to-entry time outside the age wait: flag set, decision, two sequencer steps
    localparam int VIA_ENTRY_CLK  = 4;
    localparam logic [3:0] VIA_AGE_HI = 4'(VIA_LAT_HI_CLK - VIA_ENTRY_CLK);
    localparam logic [3:0] VIA_AGE_LO = 4'(VIA_LAT_LO_CLK - VIA_ENTRY_CLK);

    // AHB-Lite transfer type bit that marks an active transfer
    localparam int VIA_HTRANS_ACTIVE_BIT = 1;

    // Entry sequencer states, one-hot
    typedef enum logic [3:0] {
        VIA_ST_IDLE = 4'b0001,
        VIA_ST_PUSH_PSW = 4'b0010,
        VIA_ST_PUSH_PC  = 4'b0100,
        VIA_ST_LOAD_VEC = 4'b1000
    } via_state_t;

endpackage : via_pkg

// *** rtl/via_core.sv ***
/*
 * Vectored interrupt acknowledge and entry sequencer with AHB-Lite registers.
 * Assumes the CPU sequencer reports each instruction boundary with a pulse,
 * stalls while entry is busy, and supplies the popped status word on returns.
 */
// Local design decisions: the register offsets and the AHB-Lite register port.
// Function
// - A request is acknowledgeable only when its flag is 1 and mask 0.
// - Vectored requests are accepted only while the global accept flag is 1.
// - Service level flag 0 refuses low-priority maskable requests outside a trap handler.
// - Entry no sooner than 7 clocks (high) or 8 (low); worst 32/33.
// - A divide in progress delays entry beyond the normal worst case.
// - Among simultaneous requests the higher programmed level wins.
// - Equal levels are resolved by fixed order, lowest index first.
// - Unacknowledged requests stay pending until all conditions hold.
// - Maskable entry pushes status then PC, clears accept, copies level, vectors.
// - Return-from-handler ends servicing and restores saved state.
// - Soft trap always enters: push status, PC, clear accept, vector 003EH.
// - Nesting takes equal or higher priority; lower stays pending.
// - After a return, one program instruction runs before a pending entry.
// - Level 0 accepts only high requests and traps; level 1 or trap accepts all.
// - Status, enable, return and flag-register instructions defer one instruction.
// - Soft trap does not defer, but clearing accept blocks maskable entry.
// - Programmed level never affects how request flags get set.
// - Service level flag is 0 for high handlers, 1 when idle or low.
// - Reset loads status word 02H: accept off, service level idle.
`timescale 1ns/1ps
`default_nettype none

module via_core
    import via_pkg::*;
#(
    parameter int NSRC = 16
)(
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Peripheral request pulses
    input  wire logic [NSRC-1:0]   req_set,
    // CPU sequencer
    input  wire logic              instr_done,
    input  wire logic              instr_hold,
    input  wire logic              unmask_all_op,
    input  wire logic              mask_all_op,
    input  wire logic              soft_trap_op,
    input  wire logic              return_from_handler_op,
    input  wire logic              return_from_trap_op,
    input  wire logic [7:0]        restored_psw,
    input  wire logic              psw_wr,
    input  wire logic [7:0]        psw_wdata,
    output logic                   entry_busy,
    output logic                   push_psw,
    output logic                   push_pc,
    output logic [7:0]             stack_psw,
    output logic                   pc_load,
    output logic [15:0]            vector_addr,
    output logic [7:0]             program_status_word
);

    // Index width of one source
    localparam int SW = $clog2(NSRC);

    // Held state
    // The stack itself lives in the CPU
    logic [NSRC-1:0] request_flag_q;
    logic [NSRC-1:0] mask_flag_q;
    logic [NSRC-1:0] level_select_flag_q;
    logic [7:0]      psw_q;
    logic            in_trap_q;
    logic            hold_q;
    via_state_t      state_q;
    logic [SW-1:0]   src_q;
    logic            src_trap_q;
    logic [3:0]      age_q [NSRC];

    // AHB data phase state
    logic            dp_wr_q;
    logic [7:0]      dp_ofs_q;
    logic [31:0]     rdata_q;

    // Decision terms
    // All settle within each cycle
    logic            global_accept_flag;
    logic            service_level_flag;
    logic [NSRC-1:0] eligible;
    logic            win_any;
    logic [SW-1:0]   win_idx;
    logic            boundary_ok;
    logic            take_mask;
    logic            take_trap;
    logic [NSRC-1:0] ack_clr;

    assign global_accept_flag = psw_q[VIA_PSW_ACCEPT_BIT];
    assign service_level_flag = psw_q[VIA_PSW_LEVEL_BIT];

    // Age counters gate the least latency; saturate so long waits never wrap
    // Four bits clear the largest threshold
    genvar g;
    generate
        for (g = 0; g < NSRC; g++)
        begin : g_age
            always_ff @(posedge sys_clk or negedge arst_n)
            begin
                if (!arst_n)
                    age_q[g] <= 4'h0;
                else if (!request_flag_q[g] || ack_clr[g])
                    age_q[g] <= 4'h0;
                else if (age_q[g] != 4'hf)
                    age_q[g] <= age_q[g] + 4'h1;
            end

            // Eligibility per source: flag, mask, service level and age
            // A trap handler takes every level
            always_comb
            begin
                eligible[g] = request_flag_q[g] && !mask_flag_q[g]
                    && (!level_select_flag_q[g] || service_level_flag || in_trap_q)
                    && (age_q[g] >= (level_select_flag_q[g] ? VIA_AGE_LO : VIA_AGE_HI));
            end
        end
    endgenerate

    // Winner: any high-level source first, then low; lowest index within a level
    // Downward scan, so the lowest index wins last
    always_comb
    begin
        win_any = 1'b0;
        win_idx = '0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (eligible[i] && !level_select_flag_q[i])
            begin
                win_any = 1'b1;
                win_idx = SW'(i);
            end
        end
        if (!win_any)
        begin
            for (int i = NSRC - 1; i >= 0; i--)
            begin
                if (eligible[i])
                begin
                    win_any = 1'b1;
                    win_idx = SW'(i);
                end
            end
        end
    end

    // Decisions only at a boundary; a deferring instruction blocks its own
    // boundary only, so the next instruction runs and entry may follow it.
    // A divide simply withholds the boundary pulse.
    assign boundary_ok = instr_done && (state_q == VIA_ST_IDLE);
    assign take_trap   = boundary_ok && soft_trap_op;
    assign take_mask   = boundary_ok && !soft_trap_op && !instr_hold
                         && !unmask_all_op && !mask_all_op
                         && !return_from_handler_op && !return_from_trap_op
                         && global_accept_flag && win_any;

    // Winning flag clears at the decision edge
    always_comb
    begin
        ack_clr = '0;
        if (take_mask)
            ack_clr[win_idx] = 1'b1;
    end

    // Last boundary ended a deferring instruction; kept for status reads
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            hold_q <= 1'b0;
        else if (instr_done)
            hold_q <= instr_hold || unmask_all_op || mask_all_op
                      || return_from_handler_op || return_from_trap_op;
    end

    // Entry sequencer: push status, push PC, load vector
    // The CPU stalls on entry_busy meanwhile
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= VIA_ST_IDLE;
        else
        begin
            unique case (state_q)
                VIA_ST_IDLE:     if (take_mask || take_trap) state_q <= VIA_ST_PUSH_PSW;
                VIA_ST_PUSH_PSW: state_q <= VIA_ST_PUSH_PC;
                VIA_ST_PUSH_PC:  state_q <= VIA_ST_LOAD_VEC;
                VIA_ST_LOAD_VEC: state_q <= VIA_ST_IDLE;
                default:         state_q <= VIA_ST_IDLE;
            endcase
        end
    end

    // Chosen source and old status word, captured at the decision
    // Taken before the accept clear lands
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            src_q      <= '0;
            src_trap_q <= 1'b0;
            stack_psw  <= 8'h00;
        end
        else if (take_mask || take_trap)
        begin
            src_q      <= win_idx;
            src_trap_q <= take_trap;
            stack_psw  <= psw_q;
        end
    end

    // Sequencer outputs, each from a flop
    // Busy spans the vector load cycle too
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            entry_busy  <= 1'b0;
            push_psw    <= 1'b0;
            push_pc     <= 1'b0;
            pc_load     <= 1'b0;
            vector_addr <= 16'h0000;
        end
        else
        begin
            entry_busy <= (take_mask || take_trap) || (state_q == VIA_ST_PUSH_PSW)
                          || (state_q == VIA_ST_PUSH_PC);
            push_psw   <= (take_mask || take_trap);
            push_pc    <= (state_q == VIA_ST_PUSH_PSW);
            pc_load    <= (state_q == VIA_ST_PUSH_PC);
            // Entries sit two bytes apart
            if (state_q == VIA_ST_PUSH_PC)
                vector_addr <= src_trap_q ? VIA_VEC_TRAP
                             : 16'(VIA_VEC_BASE + {15'h0000, src_q, 1'b0});
        end
    end

    // Status word: entry, returns, enable ops and sequencer writes
    // Sequencer writes rank last
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            psw_q <= VIA_PSW_RESET;
        else if (take_mask)
        begin
            psw_q[VIA_PSW_ACCEPT_BIT] <= 1'b0;
            psw_q[VIA_PSW_LEVEL_BIT]  <= level_select_flag_q[win_idx];
        end
        else if (take_trap)
            psw_q[VIA_PSW_ACCEPT_BIT] <= 1'b0;
        else if (instr_done && (return_from_handler_op || return_from_trap_op))
            psw_q <= restored_psw;
        else if (instr_done && unmask_all_op)
            psw_q[VIA_PSW_ACCEPT_BIT] <= 1'b1;
        else if (instr_done && mask_all_op)
            psw_q[VIA_PSW_ACCEPT_BIT] <= 1'b0;
        else if (psw_wr)
            psw_q <= psw_wdata;
    end

    // Trap-handler marker widens the accepted set; trap return ends it
    // A maskable return inside leaves it set
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            in_trap_q <= 1'b0;
        else if (take_trap)
            in_trap_q <= 1'b1;
        else if (instr_done && return_from_trap_op)
            in_trap_q <= 1'b0;
    end

    // Mirror of the status word for the sequencer
    // One cycle late, but straight from a flop
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            program_status_word <= VIA_PSW_RESET;
        else
            program_status_word <= psw_q;
    end

    // AHB address phase capture; zero wait states, always OKAY
    // So hreadyout never drops
    logic addr_valid;
    assign addr_valid = hsel && hready && htrans[VIA_HTRANS_ACTIVE_BIT];

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dp_wr_q   <= 1'b0;
            dp_ofs_q  <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            dp_wr_q   <= addr_valid && hwrite;
            dp_ofs_q  <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Read data registered at the address phase so it stands in the data phase
    // Unmapped offsets read as zero
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_q <= 32'h0000_0000;
        else if (addr_valid && !hwrite)
        begin
            unique case (haddr[7:0])
                VIA_OFS_REQUEST: rdata_q <= 32'(request_flag_q);
                VIA_OFS_MASK:    rdata_q <= 32'(mask_flag_q);
                VIA_OFS_LEVEL:   rdata_q <= 32'(level_select_flag_q);
                VIA_OFS_PSW:     rdata_q <= {24'h000000, psw_q};
                VIA_OFS_STATUS:  rdata_q <= 32'({src_q, 5'h00, hold_q, in_trap_q,
                                                 state_q != VIA_ST_IDLE});
                default:         rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Port driven by the read flop
    assign hrdata = rdata_q;

    // Request flags: hardware set beats a software clear in the same cycle
    // A write replaces all flags; merge first
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            request_flag_q <= '0;
        else if (dp_wr_q && dp_ofs_q == VIA_OFS_REQUEST)
            request_flag_q <= hwdata[NSRC-1:0] | req_set;
        else
            request_flag_q <= (request_flag_q & ~ack_clr) | req_set;
    end

    // Mask and level flags reset to all ones: masked, low level
    // No maskable request enters before software sets up
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mask_flag_q         <= '1;
            level_select_flag_q <= '1;
        end
        else if (dp_wr_q && dp_ofs_q == VIA_OFS_MASK)
            mask_flag_q <= hwdata[NSRC-1:0];
        else if (dp_wr_q && dp_ofs_q == VIA_OFS_LEVEL)
            level_select_flag_q <= hwdata[NSRC-1:0];
    end

endmodule : via_core

`default_nettype wire

// *** sim/via_core_monitor.sv ***
/*
 * Checker for the entry sequencer and status word of via_core.
 * Bound to every via_core instance; sees its ports only.
 */
`timescale 1ns/1ps
`default_nettype none

module via_core_monitor
    import via_pkg::*;
#(
    parameter int NSRC = 16
)(
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        instr_done,
    input wire logic        soft_trap_op,
    input wire logic        entry_busy,
    input wire logic        push_psw,
    input wire logic        push_pc,
    input wire logic        pc_load,
    input wire logic [7:0]  stack_psw,
    input wire logic [15:0] vector_addr,
    input wire logic [7:0]  program_status_word
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // Trap taken at a boundary, and the end of the maskable table
    logic        trap_take;
    logic [15:0] vec_end;
    assign trap_take = instr_done & soft_trap_op;
    assign vec_end   = VIA_VEC_BASE + 16'(2 * NSRC);

    property p_entry_order; push_psw |=> push_pc ##1 pc_load; endproperty
    a_entry_order: assert property (p_entry_order) else $error("entry steps out of order");
    property p_busy_span; push_psw |-> entry_busy ##1 entry_busy ##1 entry_busy ##1 !entry_busy; endproperty
    a_busy_span: assert property (p_busy_span) else $error("busy span wrong");
    property p_boundary; $rose(push_psw) |-> $past(instr_done) && !$past(entry_busy); endproperty
    a_boundary: assert property (p_boundary) else $error("entry not at a boundary");
    property p_accept_clr; pc_load |-> !program_status_word[VIA_PSW_ACCEPT_BIT]; endproperty
    a_accept_clr: assert property (p_accept_clr) else $error("accept flag not cleared");
    property p_trap_vec; pc_load && $past(trap_take, 3) |-> vector_addr == VIA_VEC_TRAP; endproperty
    a_trap_vec: assert property (p_trap_vec) else $error("trap vector wrong");
    property p_need_accept;
        pc_load && vector_addr != VIA_VEC_TRAP |-> stack_psw[VIA_PSW_ACCEPT_BIT];
    endproperty
    a_need_accept: assert property (p_need_accept) else $error("maskable entry while disabled");
    property p_vec_range;
        pc_load |-> !vector_addr[0] && (vector_addr == VIA_VEC_TRAP ||
            (vector_addr >= VIA_VEC_BASE && vector_addr < vec_end));
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("vector outside table");
    property p_bus_okay; hreadyout && !hresp; endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
    property p_reset_psw; $rose(arst_n) |-> program_status_word == VIA_PSW_RESET; endproperty
    a_reset_psw: assert property (p_reset_psw) else $error("status word reset value wrong");

    // Main scenarios: trap, maskable, nested inside a high handler
    cover property (pc_load && vector_addr == VIA_VEC_TRAP);
    cover property (pc_load && vector_addr != VIA_VEC_TRAP);
    cover property (push_psw && stack_psw[VIA_PSW_ACCEPT_BIT] && !stack_psw[VIA_PSW_LEVEL_BIT]);
endmodule : via_core_monitor

bind via_core via_core_monitor #(.NSRC(NSRC)) u_mon (.sys_clk, .arst_n, .hreadyout, .hresp,
    .instr_done, .soft_trap_op, .entry_busy, .push_psw, .push_pc, .pc_load, .stack_psw,
    .vector_addr, .program_status_word);

`default_nettype wire

// *** sim/via_seq_model.sv ***
/*
 * Behavioural CPU sequencer: a boundary every GAP+1 cycles, stalls on entry.
 * Assumes the bench loads pend with the op bits of the next instruction.
 */
`timescale 1ns/1ps
`default_nettype none

module via_seq_model
    import via_pkg::*;
#(
    parameter int GAP = 1
)(
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic        entry_busy,
    input wire logic        pc_load,
    input wire logic [7:0]  stack_psw,
    output logic            instr_done,
    output logic            instr_hold,
    output logic            unmask_all_op,
    output logic            mask_all_op,
    output logic            soft_trap_op,
    output logic            return_from_handler_op,
    output logic            return_from_trap_op,
    output logic [7:0]      restored_psw
);
    // Op bits: hold, unmask, mask, trap, return, trap return
    logic [5:0] pend = 6'h00;
    logic [7:0] stk[$];

    // Stack of saved status words, popped by both returns
    always @(posedge sys_clk)
        if (pc_load) stk.push_back(stack_psw);

    // Never signals a boundary while the entry sequence runs
    initial
    begin
        {instr_done, instr_hold, unmask_all_op, mask_all_op} = 4'h0;
        {soft_trap_op, return_from_handler_op, return_from_trap_op} = 3'h0;
        restored_psw = VIA_PSW_RESET;
        forever
        begin
            @(posedge sys_clk);
            if (arst_n && !entry_busy && !pc_load)
            begin
                {instr_hold, unmask_all_op, mask_all_op, soft_trap_op,
                 return_from_handler_op, return_from_trap_op} <= pend;
                if ((pend[1] || pend[0]) && stk.size() > 0) restored_psw <= stk.pop_back();
                pend = 6'h00;
                instr_done <= 1'b1;
                @(posedge sys_clk);
                {instr_done, instr_hold, unmask_all_op, mask_all_op} <= 4'h0;
                {soft_trap_op, return_from_handler_op, return_from_trap_op} <= 3'h0;
                repeat (GAP - 1) @(posedge sys_clk);
            end
        end
    end
endmodule : via_seq_model

`default_nettype wire

// *** sim/vectored_interrupt_acknowledge_tb_top.sv ***
/*
 * Self-checking bench for via_core with a sequencer model and AHB-Lite tasks.
 * Assumes zero-wait slave answers and the default of 16 sources.
 */
`timescale 1ns/1ps
`default_nettype none

module vectored_interrupt_acknowledge_tb_top
    import via_pkg::*;
;
    localparam logic [5:0] OP_EI   = 6'h30;
    localparam logic [5:0] OP_DI   = 6'h28;
    localparam logic [5:0] OP_BRK  = 6'h04;
    localparam logic [5:0] OP_RETURN_FROM_HANDLER_OP = 6'h22;
    localparam logic [5:0] OP_RETURN_FROM_TRAP_OP = 6'h21;

    logic        sys_clk, arst_n, hsel, hwrite, hreadyout, hresp, entry_busy;
    logic        push_psw, push_pc, pc_load, instr_done, instr_hold, unmask_all_op;
    logic        mask_all_op, soft_trap_op, return_from_handler_op, return_from_trap_op;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [15:0] req_set, vector_addr;
    logic [7:0]  restored_psw, stack_psw, program_status_word;
    wire logic   hready = hreadyout;
    int          error_cnt = 0;
    int          n_tests = 0;

    via_core dut (.sys_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .req_set, .instr_done, .instr_hold, .unmask_all_op,
        .mask_all_op, .soft_trap_op, .return_from_handler_op, .return_from_trap_op,
        .restored_psw, .psw_wr(1'b0), .psw_wdata(8'h00), .entry_busy, .push_psw, .push_pc,
        .stack_psw, .pc_load, .vector_addr, .program_status_word);
    via_seq_model u_seq (.sys_clk, .arst_n, .entry_busy, .pc_load, .stack_psw, .instr_done,
        .instr_hold, .unmask_all_op, .mask_all_op, .soft_trap_op, .return_from_handler_op,
        .return_from_trap_op, .restored_psw);

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    task automatic tmo;
        error_cnt++;
        $display("[ERR] wait limit exp done got hang");
        stop_test();
    endtask : tmo

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    // One single word transfer; the address phase is held until hready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n = 0;
        @(posedge sys_clk);
        {hsel, hwrite, htrans, haddr} <= {1'b1, wr, 2'b10, 24'h0, a};
        do begin @(posedge sys_clk); n++; end while (!hreadyout && n < 50);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        do begin @(posedge sys_clk); n++; end while (!hreadyout && n < 50);
        q = hrdata;
        if (n >= 50) tmo();
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk("register", q, exp);
    endtask : rdc

    task automatic op(input logic [5:0] x);
        int n = 0;
        u_seq.pend = x;
        while (u_seq.pend !== 6'h00 && n < 100) begin @(posedge sys_clk); n++; end
        if (n >= 100) tmo();
    endtask : op

    task automatic pulse(input logic [15:0] m);
        @(posedge sys_clk);
        req_set <= m;
        @(posedge sys_clk);
        req_set <= 16'h0000;
    endtask : pulse

    // Cycles counted from the call to the vector load; t_latency, t_priority and t_nesting call it right after a request pulse
    task automatic entry(input logic [15:0] v, input int lo, input int hi);
        int n = 0;
        while (!pc_load && n < hi + 10) begin @(posedge sys_clk); n++; end
        if (!pc_load) tmo();
        chk("vector", 32'(vector_addr), 32'(v));
        chk("latency", 32'(n >= lo && n <= hi), 32'h1);
        chk("accept", 32'(program_status_word[VIA_PSW_ACCEPT_BIT]), 32'h0);
    endtask : entry

    task automatic no_entry(input int cyc);
        logic seen = 1'b0;
        repeat (cyc) begin @(posedge sys_clk); seen |= pc_load; end
        chk("no_entry", 32'(seen), 32'h0);
    endtask : no_entry

    task automatic t_reset;
        chk("psw_port", 32'(program_status_word), 32'(VIA_PSW_RESET));
        rdc(VIA_OFS_PSW, 32'h02);
        rdc(VIA_OFS_MASK, 32'hffff);
        rdc(VIA_OFS_LEVEL, 32'hffff);
        rdc(VIA_OFS_REQUEST, 32'h0);
        rdc(8'h40, 32'h0);
        $display("reset test done");
    endtask : t_reset

    task automatic t_latency;
        wr(VIA_OFS_MASK, 32'hfff0);
        wr(VIA_OFS_LEVEL, 32'hfffe);
        op(OP_EI);
        pulse(16'h0001);
        entry(16'h0004, VIA_LAT_HI_CLK, VIA_LAT_HI_MAX_CLK);
        chk("level", 32'(program_status_word[VIA_PSW_LEVEL_BIT]), 32'h0);
        op(OP_RETURN_FROM_HANDLER_OP);
        repeat (3) @(posedge sys_clk);
        chk("restored", 32'(program_status_word), 32'h82);
        pulse(16'h0002);
        entry(16'h0006, VIA_LAT_LO_CLK, VIA_LAT_LO_MAX_CLK);
        chk("level", 32'(program_status_word[VIA_PSW_LEVEL_BIT]), 32'h1);
        op(OP_RETURN_FROM_HANDLER_OP);
        $display("latency test done");
    endtask : t_latency

    task automatic t_pending;
        pulse(16'h0010);
        no_entry(30);
        wr(VIA_OFS_MASK, 32'hffe0);
        entry(16'h000c, 0, 60);
        op(OP_RETURN_FROM_HANDLER_OP);
        op(OP_DI);
        pulse(16'h0001);
        no_entry(30);
        op(OP_EI);
        entry(16'h0004, 0, 60);
        op(OP_RETURN_FROM_HANDLER_OP);
        $display("pending test done");
    endtask : t_pending

    task automatic t_priority;
        wr(VIA_OFS_LEVEL, 32'hfff6);
        pulse(16'h000e);
        entry(16'h000a, 0, 60);
        op(OP_RETURN_FROM_HANDLER_OP);
        entry(16'h0006, 0, 60);
        op(OP_RETURN_FROM_HANDLER_OP);
        entry(16'h0008, 0, 60);
        op(OP_RETURN_FROM_HANDLER_OP);
        $display("priority test done");
    endtask : t_priority

    task automatic t_trap;
        op(OP_DI);
        op(OP_BRK);
        entry(VIA_VEC_TRAP, 0, 60);
        pulse(16'h0001);
        no_entry(20);
        op(OP_RETURN_FROM_TRAP_OP);
        repeat (3) @(posedge sys_clk);
        chk("restored", 32'(program_status_word), 32'(VIA_PSW_RESET));
        op(OP_EI);
        entry(16'h0004, 0, 60);
        op(OP_RETURN_FROM_HANDLER_OP);
        $display("trap test done");
    endtask : t_trap

    task automatic t_nesting;
        pulse(16'h0001);
        entry(16'h0004, 0, 60);
        op(OP_EI);
        pulse(16'h0002);
        no_entry(30);
        pulse(16'h0008);
        entry(16'h000a, 0, 60);
        op(OP_RETURN_FROM_HANDLER_OP);
        no_entry(20);
        op(OP_RETURN_FROM_HANDLER_OP);
        entry(16'h0006, 0, 60);
        op(OP_RETURN_FROM_HANDLER_OP);
        $display("nesting test done");
    endtask : t_nesting

    // Bound on the whole run
    initial
    begin
        repeat (100000) @(posedge sys_clk);
        tmo();
    end

    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        req_set = 16'h0000;
        arst_n = 1'b0;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_reset();
        t_latency();
        t_pending();
        t_priority();
        t_trap();
        t_nesting();
        stop_test();
    end
endmodule : vectored_interrupt_acknowledge_tb_top

`default_nettype wire
